/* File: rtl/scmc_top.sv */
// System clock mode controller with Wishbone register access
`timescale 1ns/10ps
`default_nettype none
`include "scmc_map.svh"

module scmc_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`SCMC_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic main_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic stop_instr,
  input wire logic irq_any,
  input wire logic key_scan_irq,
  input wire logic watch_timer_irq,
  input wire logic ext_irq,
  input wire logic event_count_pin_n,
  output logic cpu_tick,
  output logic [`SCMC_NTAP-1:0] periph_tick,
  output logic main_osc_run,
  output logic cpu_halt
);

  scmc_pkg::scmc_state_t st;
  scmc_pkg::scmc_state_t next_st;
  logic [`SCMC_NTAP-1:0] taps;
  logic src_sub;
  logic src_tick;
  logic req;
  logic wr;
  logic [1:0] mode_bits;
  logic [3:0] cpu_tap;
  logic stop_wake;

  // Oscillator selection from mode bits
  assign mode_bits = st.sys_mode[`SCMC_MODE_MSB:`SCMC_MODE_LSB];
  assign src_sub = mode_bits[1];
  assign src_tick = src_sub ? sub_osc_tick : main_osc_tick;
  assign req = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign stop_wake = key_scan_irq | watch_timer_irq | ext_irq |
    (st.ec_prev & ~event_count_pin_n);

  // CPU divider tap select
  always_comb begin
    case (st.sys_mode[`SCMC_CDIV_MSB:`SCMC_CDIV_LSB])
      2'b00: cpu_tap = `SCMC_TAP_DIV2;
      2'b01: cpu_tap = `SCMC_TAP_DIV8;
      2'b10: cpu_tap = `SCMC_TAP_DIV16;
      2'b11: cpu_tap = `SCMC_TAP_DIV64;
      default: cpu_tap = `SCMC_TAP_DIV2;
    endcase
  end

  // Shared prescaler; keeps counting across a source switch
  scmc_div u_div (
    .core_clk(core_clk),
    .srst(srst),
    .tick(src_tick),
    .taps(taps)
  );

  // Next state: bus, registers, power mode and tick outputs
  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.ec_prev = event_count_pin_n;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `SCMC_OFS_SYS_MODE: next_st.rdata = {24'h000000, st.sys_mode};
        `SCMC_OFS_PCLK_EN: next_st.rdata = {31'h0, st.pclk_en};
        `SCMC_OFS_SLEEP: next_st.rdata = {31'h0, st.sleep_bit};
        `SCMC_OFS_STATUS: next_st.rdata = {26'h0, src_sub,
          st.main_osc_run, 1'b0, st.mode};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        `SCMC_OFS_SYS_MODE: next_st.sys_mode = wb_dat_i[7:0];
        `SCMC_OFS_PCLK_EN: next_st.pclk_en =
          wb_dat_i[`SCMC_PCLK_EN_BIT];
        `SCMC_OFS_SLEEP: next_st.sleep_bit = wb_dat_i[`SCMC_SLEEP_BIT];
        default: next_st.sleep_bit = st.sleep_bit;
      endcase
    end
    // Power mode sequencing
    case (st.mode)
      scmc_pkg::SCMC_RUN: begin
        if (stop_instr) begin
          next_st.mode = scmc_pkg::SCMC_STOP;
        end else if (st.sleep_bit) begin
          next_st.mode = scmc_pkg::SCMC_SLEEP;
        end
      end
      scmc_pkg::SCMC_SLEEP: begin
        if (irq_any) begin
          next_st.mode = scmc_pkg::SCMC_RUN;
          // A sleep write in the wake cycle wins over the clear
          if (!(wr && wb_adr_i == `SCMC_OFS_SLEEP)) begin
            next_st.sleep_bit = 1'b0;
          end
        end
      end
      scmc_pkg::SCMC_STOP: begin
        if (stop_wake) begin
          next_st.mode = scmc_pkg::SCMC_RUN;
        end
      end
      default: next_st.mode = scmc_pkg::SCMC_RUN;
    endcase
    // Main oscillator stops in 11 or in STOP; 10 restarts it
    next_st.main_osc_run = (mode_bits != `SCMC_MODE_SUB_OFF) &&
      (st.mode != scmc_pkg::SCMC_STOP);
    next_st.cpu_halt = (st.mode != scmc_pkg::SCMC_RUN);
    // CPU tick only in run; switch does not pause it
    next_st.cpu_tick = (st.mode == scmc_pkg::SCMC_RUN) &
      taps[cpu_tap];
    // Peripheral taps gated by enable, held off in STOP
    next_st.periph_tick = (st.pclk_en &&
      st.mode != scmc_pkg::SCMC_STOP) ? taps :
      {`SCMC_NTAP{1'b0}};
  end

  // State register; reset lands in main-clock run mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
      st.mode <= scmc_pkg::SCMC_RUN;
      st.sys_mode <= `SCMC_SYS_MODE_RST;
      st.pclk_en <= 1'b0;
      st.sleep_bit <= 1'b0;
      st.main_osc_run <= 1'b1;
      st.ec_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign cpu_tick = st.cpu_tick;
  assign periph_tick = st.periph_tick;
  assign main_osc_run = st.main_osc_run;
  assign cpu_halt = st.cpu_halt;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_stop_enter;
    st.mode == scmc_pkg::SCMC_RUN && stop_instr;
  endsequence

  sequence s_in_stop;
    st.mode == scmc_pkg::SCMC_STOP;
  endsequence

  a_cpu_div_ratio: assert property (
    st.cpu_tick |-> $past(st.mode == scmc_pkg::SCMC_RUN) &&
      $past(taps[cpu_tap]))
  else $error("cpu tick without selected tap");

  a_periph_undiv: assert property (
    st.pclk_en && st.mode == scmc_pkg::SCMC_RUN && src_tick
      && !stop_instr |=> periph_tick[0])
  else $error("undivided peripheral tick missing");

  a_periph_gate: assert property (
    !st.pclk_en |=> periph_tick == {`SCMC_NTAP{1'b0}})
  else $error("peripheral tick while disabled");

  a_reset_values: assert property (
    $past(srst) |-> st.sys_mode == 8'h00 && !st.pclk_en &&
      st.mode == scmc_pkg::SCMC_RUN)
  else $error("reset values wrong");

  a_sub_main_off: assert property (
    mode_bits == `SCMC_MODE_SUB_OFF |=> !main_osc_run)
  else $error("main oscillator runs in 11 mode");

  a_sleep_halts: assert property (
    st.mode == scmc_pkg::SCMC_SLEEP |=> !cpu_tick ##0 cpu_halt)
  else $error("cpu ticks in sleep");

  a_sleep_wake: assert property (
    st.mode == scmc_pkg::SCMC_SLEEP && irq_any |=>
      st.mode == scmc_pkg::SCMC_RUN ##1 !cpu_halt)
  else $error("sleep not left on interrupt");

  a_stop_halts: assert property (
    s_stop_enter ##1 s_in_stop |=> !main_osc_run &&
      periph_tick == {`SCMC_NTAP{1'b0}} && !cpu_tick)
  else $error("stop does not halt");

  a_stop_wake: assert property (
    s_in_stop ##0 (key_scan_irq || watch_timer_irq || ext_irq) |=>
      st.mode == scmc_pkg::SCMC_RUN)
  else $error("stop not released by wake source");

  a_bus_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
  else $error("ack not a single cycle");

  // Power mode checks
  // Sleep state for the checks below
  sequence s_in_sleep;
    st.mode == scmc_pkg::SCMC_SLEEP;
  endsequence

  a_stop_enter: assert property (
    s_stop_enter |=> s_in_stop)
  else $error("stop instruction not taken");

  a_sleep_enter: assert property (
    st.mode == scmc_pkg::SCMC_RUN && st.sleep_bit && !stop_instr |=>
      s_in_sleep)
  else $error("sleep bit does not enter sleep");

  a_stop_ignored: assert property (
    s_in_sleep ##0 (stop_instr && !irq_any) |=> s_in_sleep)
  else $error("stop taken outside run");

  a_pin_wake: assert property (
    s_in_stop ##0 (st.ec_prev && !event_count_pin_n) |=>
      st.mode == scmc_pkg::SCMC_RUN)
  else $error("stop not released by event pin");

  a_halt_run: assert property (
    st.mode == scmc_pkg::SCMC_RUN |=> !cpu_halt)
  else $error("cpu halted in run mode");

  // Reset, oscillator and sleep peripheral checks
  a_reset_main: assert property (
    $past(srst) |-> st.main_osc_run && !src_sub && !st.cpu_halt)
  else $error("reset does not resume main clock");

  a_sub_source: assert property (
    mode_bits == `SCMC_MODE_SUB_OFF && st.pclk_en &&
      st.mode == scmc_pkg::SCMC_RUN |=>
      periph_tick[0] == $past(sub_osc_tick))
  else $error("sub mode not driven by sub oscillator");

  a_main_restart: assert property (
    mode_bits == `SCMC_MODE_SUB && st.mode != scmc_pkg::SCMC_STOP |=>
      main_osc_run)
  else $error("main oscillator not running in 10 mode");

  a_sleep_periph: assert property (
    s_in_sleep ##0 (st.pclk_en && src_tick) |=> periph_tick[0])
  else $error("peripherals stop in sleep");

  // Register bus checks
  a_mode_write: assert property (
    wr && wb_adr_i == `SCMC_OFS_SYS_MODE |=>
      st.sys_mode == $past(wb_dat_i[7:0]))
  else $error("mode register write lost");

  a_pclk_write: assert property (
    wr && wb_adr_i == `SCMC_OFS_PCLK_EN |=>
      st.pclk_en == $past(wb_dat_i[`SCMC_PCLK_EN_BIT]))
  else $error("peripheral enable write lost");

  a_sel_ignore: assert property (
    req && wb_we_i && !wb_sel_i[0] |=>
      $stable(st.sys_mode) && $stable(st.pclk_en))
  else $error("write without byte lane taken");

  a_read_back: assert property (
    req && !wb_we_i && wb_adr_i == `SCMC_OFS_SYS_MODE |=>
      wb_dat_o == {24'h000000, $past(st.sys_mode)})
  else $error("mode register read back wrong");

endmodule : scmc_top
`default_nettype wire

/* File: rtl/scmc_map.svh */
// Register offsets, field positions and reset values of the clock controller
`ifndef SCMC_MAP_SVH
`define SCMC_MAP_SVH

`define SCMC_ADR_W 8
`define SCMC_OFS_SYS_MODE 8'h00
`define SCMC_OFS_PCLK_EN 8'h04
`define SCMC_OFS_SLEEP 8'h08
`define SCMC_OFS_STATUS 8'h0c

`define SCMC_SYS_MODE_RST 8'h00
`define SCMC_PCLK_EN_RST 8'h00
`define SCMC_SLEEP_RST 8'h00

`define SCMC_MODE_LSB 0
`define SCMC_MODE_MSB 1
`define SCMC_CDIV_LSB 2
`define SCMC_CDIV_MSB 3
`define SCMC_PCLK_EN_BIT 0
`define SCMC_SLEEP_BIT 0

`define SCMC_MODE_MAIN 2'b00
`define SCMC_MODE_SUB 2'b10
`define SCMC_MODE_SUB_OFF 2'b11

`define SCMC_TAP_DIV2 4'h1
`define SCMC_TAP_DIV8 4'h3
`define SCMC_TAP_DIV16 4'h4
`define SCMC_TAP_DIV64 4'h6
`define SCMC_NTAP 11

`endif

/* File: rtl/scmc_pkg.sv */
// Types shared by the clock mode controller files
package scmc_pkg;

  typedef enum logic [2:0] {
    SCMC_RUN = 3'b001,
    SCMC_SLEEP = 3'b010,
    SCMC_STOP = 3'b100
  } scmc_mode_t;

  typedef struct packed {
    scmc_mode_t mode;
    logic [7:0] sys_mode;
    logic pclk_en;
    logic sleep_bit;
    logic ack;
    logic [31:0] rdata;
    logic cpu_tick;
    logic [10:0] periph_tick;
    logic main_osc_run;
    logic cpu_halt;
    logic ec_prev;
  } scmc_state_t;

  typedef struct packed {
    logic [9:0] cnt;
  } scmc_div_state_t;

endpackage : scmc_pkg

/* File: rtl/scmc_div.sv */
// Power-of-two prescaler producing tick taps from 1 to 1024
`timescale 1ns/10ps
`default_nettype none
`include "scmc_map.svh"

module scmc_div (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tick,
  output logic [`SCMC_NTAP-1:0] taps
);

  scmc_pkg::scmc_div_state_t st;
  scmc_pkg::scmc_div_state_t next_st;

  // Count source ticks
  always_comb begin
    next_st = st;
    if (tick) begin
      next_st.cnt = st.cnt + 10'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Tap k pulses once every 2^k source ticks
  assign taps[0] = tick;
  genvar k;
  generate
    for (k = 1; k < `SCMC_NTAP; k++) begin : g_tap
      assign taps[k] = tick & (&st.cnt[k-1:0]);
    end
  endgenerate

endmodule : scmc_div
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the system clock mode controller
`timescale 1ns/10ps
`default_nettype none
`include "scmc_map.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] bsel = 4'hf;
  logic [31:0] rdat;
  logic ack, cpu_tick, mrun, halt;
  logic [10:0] ptick;
  logic mtick = 1'b0;
  logic stick = 1'b0;
  logic stp = 1'b0;
  logic irq = 1'b0;
  logic [3:0] wk = 4'h0;
  logic [1:0] ph = 2'h0;
  logic [31:0] r;
  int errors = 0;
  int tests_run = 0;
  int c, p;
  logic [7:0] v;

  scmc_top u_dut (
    .core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .main_osc_tick(mtick),
    .sub_osc_tick(stick), .stop_instr(stp), .irq_any(irq),
    .key_scan_irq(wk[0]), .watch_timer_irq(wk[1]), .ext_irq(wk[2]),
    .event_count_pin_n(~wk[3]), .cpu_tick(cpu_tick), .periph_tick(ptick),
    .main_osc_run(mrun), .cpu_halt(halt)
  );

  // Clock and oscillator pulses: main every cycle, sub every fourth
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    ph <= ph + 2'h1;
    mtick <= 1'b1;
    stick <= (ph == 2'h0);
  end

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : check

  task automatic close_out;
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // Classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= bsel;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge core_clk);
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check("read", e, r);
  endtask : rdchk

  // Count cpu ticks and divide-by-8 peripheral ticks after settling
  task automatic cnt(input int n);
    repeat (4) @(posedge core_clk);
    c = 0;
    p = 0;
    repeat (n) begin
      @(posedge core_clk);
      c += int'(cpu_tick === 1'b1);
      p += int'(ptick[3] === 1'b1);
    end
  endtask : cnt

  function automatic int div_of(input logic [1:0] code);
    return (code == 2'b00) ? 2 : (code == 2'b01) ? 8 :
      (code == 2'b10) ? 16 : 64;
  endfunction : div_of

  function automatic logic [31:0] stat(input logic [2:0] m, input logic run,
                                       input logic sub);
    return {26'h0, sub, run, 1'b0, m};
  endfunction : stat

  task automatic pulse_rst;
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
  endtask : pulse_rst

  // Main sequence
  initial begin
    void'($urandom(92920));
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h0c, stat(3'b001, 1'b1, 1'b0));
    bsel = 4'he;
    wb(1'b1, 8'h00, 32'h000000ff);
    bsel = 4'hf;
    rdchk(8'h00, 32'h0);
    cnt(128);
    check("periph off", 0, p);
    wb(1'b1, 8'h04, 32'h1);
    for (int i = 0; i < 4; i++) begin
      v = {4'($urandom), 2'(i), 2'b00};
      wb(1'b1, 8'h00, {24'h0, v});
      rdchk(8'h00, {24'h0, v});
      cnt(128);
      check("cpu div", 128 / div_of(2'(i)), c);
      check("periph div", 16, p);
    end
    wb(1'b1, 8'h04, 32'h0);
    cnt(64);
    check("gate", 0, p);
    rdchk(8'h10, 32'h0);
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b1, 8'h00, 32'h2);
    rdchk(8'h0c, stat(3'b001, 1'b1, 1'b1));
    cnt(128);
    check("sub cpu", 16, c);
    check("sub periph", 4, p);
    wb(1'b1, 8'h00, 32'h3);
    rdchk(8'h0c, stat(3'b001, 1'b0, 1'b1));
    cnt(128);
    check("sub run", 16, c);
    check("sub off periph", 4, p);
    wb(1'b1, 8'h00, 32'h2);
    rdchk(8'h0c, stat(3'b001, 1'b1, 1'b1));
    repeat (20) @(posedge core_clk);
    wb(1'b1, 8'h00, 32'h0);
    rdchk(8'h0c, stat(3'b001, 1'b1, 1'b0));
    cnt(128);
    check("main back", 64, c);
    check("main periph", 16, p);
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h00, 32'h3);
    pulse_rst();
    rdchk(8'h0c, stat(3'b001, 1'b1, 1'b0));
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b1, 8'h08, 32'h1);
    stp <= 1'b1;
    @(posedge core_clk);
    stp <= 1'b0;
    cnt(128);
    check("sleep halt", 1, halt);
    check("sleep cpu", 0, c);
    check("sleep periph", 16, p);
    check("sleep osc", 1, mrun);
    irq <= 1'b1;
    repeat (4) @(posedge core_clk);
    irq <= 1'b0;
    check("sleep wake", 0, halt);
    rdchk(8'h08, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h00, 32'h2);
      stp <= 1'b1;
      @(posedge core_clk);
      stp <= 1'b0;
      repeat (4) @(posedge core_clk);
      check("stop halt", 1, halt);
      check("stop osc", 0, mrun);
      if (i < 4) wk <= 4'(1 << i);
      else pulse_rst();
      repeat (4) @(posedge core_clk);
      wk <= 4'h0;
      check("stop wake", 0, halt);
    end
    rdchk(8'h0c, stat(3'b001, 1'b1, 1'b0));
    close_out();
  end

  // Watchdog against a hung handshake
  initial begin
    #100000;
    errors++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
